/* File: rtl/sd_host_rx.sv */
// What this block does
// - 256-bit level skips ready for up to 3 trailing bytes
// - Threshold bit picks 256 or 128 bits
// - Empty when held bytes below access size
// - Full when free space below access size
// - 32-byte FIFO, access width from field
// - Card interrupt taken from DAT1 edge
// - Low DAT1 before enable goes unseen
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module sd_host_rx
  import sd_host_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  // Card bus pins
  input  wire logic              sd_clk_in,
  input  wire logic [3:0]        sd_dat_in,
  // System signalling
  output logic                   irq_out,
  output logic                   dma_rd_event_out
);

  // Pin synchronisers and link edge finder
  logic [1:0]  clk_sync_r;   // sd_clk_in, two stages
  logic        clk_prev_r;   // Previous synced clock
  logic [3:0]  dat_s1_r;     // First stage, read only by second
  logic [3:0]  dat_s2_r;     // Synced data lines
  logic        dat1_prev_r;  // DAT1 one cycle back
  logic        link_rise;    // Rising card clock seen
  // Software registers
  logic [DATA_W-1:0] cmd_r;
  logic              trig_r;
  logic              lev_r;
  logic [1:0]        acc_r;
  logic [DATA_W-1:0] st_r;
  logic [DATA_W-1:0] mask_r;
  logic [BLEN_W-1:0] blen_r;
  logic [NBLK_W-1:0] nblk_r;
  logic              cist_r;
  logic              cien_r;
  // Receive path
  xfer_state_t       state_r;
  logic              half_r;    // High nibble held
  logic [3:0]        hi_r;
  logic [TOT_W-1:0]  rx_cnt_r;  // Bytes taken this transfer
  logic [TOT_W-1:0]  total;     // Bytes expected
  logic              byte_vld;
  logic              last_byte;
  logic              trail_rem;
  // FIFO
  logic [7:0]        mem [0:31];
  logic [4:0]        wr_ptr_r;
  logic [4:0]        rd_ptr_r;
  logic [5:0]        fifo_cnt_r;
  logic [2:0]        acc;
  logic [2:0]        pop_n;
  logic              push;
  logic              fifo_empty;
  logic              fifo_full;
  logic [7:0]        lane [0:3];
  // Events
  logic [5:0]        thr;
  logic              rdy_cond;
  logic              rdy_cond_q;
  logic              trail_evt;
  logic              card_edge;
  logic              idle;
  logic              wr_cmd;

  // Two flops ahead of any logic on pin inputs
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      clk_sync_r  <= 2'h0;
      clk_prev_r  <= 1'b0;
      dat_s1_r    <= 4'hf;
      dat_s2_r    <= 4'hf;
      dat1_prev_r <= 1'b1;
    end else begin
      clk_sync_r  <= {clk_sync_r[0], sd_clk_in};
      clk_prev_r  <= clk_sync_r[1];
      dat_s1_r    <= sd_dat_in;
      dat_s2_r    <= dat_s1_r;
      dat1_prev_r <= dat_s2_r[1];
    end
  end

  // Clock and data pass equal stages, so they stay aligned
  assign link_rise = clk_sync_r[1] & ~clk_prev_r;
  assign idle      = (state_r == XS_IDLE);
  assign wr_cmd    = reg_wr_in && (reg_addr_in == OFF_CMD);

  // Transfer size and trailing remainder
  assign total     = TOT_W'(blen_r) * TOT_W'(nblk_r);
  assign trail_rem = (total[4:0] != 5'h00) && (total[4:0] <= TRAIL_MAX);
  assign byte_vld  = (state_r == XS_RECV) && link_rise && half_r;
  assign last_byte = byte_vld && (TOT_W'(rx_cnt_r + 1'b1) == total);

  // FIFO flags follow the access size
  assign acc        = acc_bytes(acc_r);
  assign fifo_empty = fifo_cnt_r < {3'h0, acc};
  assign fifo_full  = 6'(FIFO_BYTES - fifo_cnt_r) < {3'h0, acc};
  // A byte arriving into a full FIFO is dropped; no stall on card side
  assign push  = byte_vld && (fifo_cnt_r != FIFO_BYTES);
  assign pop_n = (reg_rd_in && reg_addr_in == OFF_DATA && !fifo_empty) ? acc : 3'h0;

  // Ready condition and the trailing-byte gap
  assign thr       = lev_r ? THR_HI : THR_LO;
  assign rdy_cond  = !idle && (fifo_cnt_r >= thr);
  assign trail_evt = last_byte && !(lev_r && trail_rem);
  // Falling DAT1 while enabled and outside data phases
  assign card_edge = dat1_prev_r && !dat_s2_r[1] && cien_r && idle;

  // Receive sequencer
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_r <= XS_IDLE;
    end else begin
      case (state_r)
        XS_IDLE: begin
          // Without the trigger bit no transfer starts
          if (wr_cmd && reg_wdata_in[CMD_TRIG]) begin
            state_r <= XS_RECV;
          end
        end
        XS_RECV: begin
          if (last_byte) begin
            state_r <= XS_DRAIN;
          end
        end
        XS_DRAIN: begin
          if (fifo_cnt_r == 6'h00) begin
            state_r <= XS_IDLE;
          end
        end
        default: state_r <= XS_IDLE;
      endcase
    end
  end

  // Nibble pairing, high nibble first, and byte count
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      half_r   <= 1'b0;
      hi_r     <= 4'h0;
      rx_cnt_r <= '0;
    end else if (state_r != XS_RECV) begin
      half_r   <= 1'b0;
      rx_cnt_r <= '0;
    end else if (link_rise) begin
      half_r <= ~half_r;
      if (!half_r) begin
        hi_r <= dat_s2_r;
      end else begin
        rx_cnt_r <= TOT_W'(rx_cnt_r + 1'b1);
      end
    end
  end

  // FIFO storage; data words need no reset
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= {hi_r, dat_s2_r};
    end
  end

  // FIFO pointers and fill count
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wr_ptr_r   <= 5'h00;
      rd_ptr_r   <= 5'h00;
      fifo_cnt_r <= 6'h00;
    end else begin
      wr_ptr_r   <= 5'(wr_ptr_r + {4'h0, push});
      rd_ptr_r   <= 5'(rd_ptr_r + {2'h0, pop_n});
      fifo_cnt_r <= 6'(fifo_cnt_r + {5'h0, push} - {3'h0, pop_n});
    end
  end

  // Read lanes, little-endian; lanes past the access size read zero
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane[g] = (3'(g) < acc) ? mem[5'(rd_ptr_r + 5'(g))] : 8'h00;
  end

  // Software-written control registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cmd_r  <= '0;
      trig_r <= 1'b0;
      lev_r  <= 1'b0;
      acc_r  <= ACC_4;
      mask_r <= '0;
      blen_r <= '0;
      nblk_r <= '0;
      cien_r <= 1'b0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        OFF_CMD: begin
          cmd_r  <= reg_wdata_in;
          trig_r <= reg_wdata_in[CMD_TRIG];
        end
        OFF_FCTL: begin
          lev_r <= reg_wdata_in[FC_LEV];
          acc_r <= reg_wdata_in[FC_ACC_HI:FC_ACC_LO];
        end
        OFF_MASK: mask_r <= reg_wdata_in & ST_BITS;
        // Lengths must match the SDIO command being issued
        OFF_BLEN: blen_r <= reg_wdata_in[BLEN_W-1:0];
        OFF_NBLK: nblk_r <= reg_wdata_in[NBLK_W-1:0];
        OFF_CIEN: cien_r <= reg_wdata_in[CI_BIT];
        default: ;
      endcase
    end
  end

  // Sticky host status; a new event beats a same-cycle clear
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      // Software may also poll done flags for odd lengths
      st_r[ST_RECV_READY_IRQ]  <= (rdy_cond | trail_evt) |
                        (st_r[ST_RECV_READY_IRQ] & ~(reg_wr_in && reg_addr_in == OFF_ST0 && reg_wdata_in[ST_RECV_READY_IRQ]));
      st_r[ST_DDONE] <= last_byte |
                        (st_r[ST_DDONE] & ~(reg_wr_in && reg_addr_in == OFF_ST0 && reg_wdata_in[ST_DDONE]));
      st_r[ST_TDONE] <= (state_r == XS_DRAIN && fifo_cnt_r == 6'h00) |
                        (st_r[ST_TDONE] & ~(reg_wr_in && reg_addr_in == OFF_ST0 && reg_wdata_in[ST_TDONE]));
    end
  end

  // Card interrupt capture; edge only, so a level held at enable is missed
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cist_r <= 1'b0;
    end else begin
      cist_r <= card_edge |
                (cist_r & ~(reg_wr_in && reg_addr_in == OFF_CIST && reg_wdata_in[CI_BIT]));
    end
  end

  // Interrupt and DMA event outputs
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdy_cond_q       <= 1'b0;
      irq_out          <= 1'b0;
      dma_rd_event_out <= 1'b0;
    end else begin
      rdy_cond_q       <= rdy_cond;
      irq_out          <= (|(st_r & mask_r)) | (cist_r & cien_r);
      dma_rd_event_out <= trig_r & ((rdy_cond & ~rdy_cond_q) | trail_evt);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= '0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          OFF_CMD:  reg_rdata_out <= cmd_r;
          OFF_FCTL: begin
            reg_rdata_out[FC_LEV]              <= lev_r;
            reg_rdata_out[FC_ACC_HI:FC_ACC_LO] <= acc_r;
          end
          OFF_ST0:  reg_rdata_out <= st_r;
          OFF_MASK: reg_rdata_out <= mask_r;
          OFF_BLEN: reg_rdata_out[BLEN_W-1:0] <= blen_r;
          OFF_NBLK: reg_rdata_out[NBLK_W-1:0] <= nblk_r;
          OFF_CIST: reg_rdata_out[CI_BIT] <= cist_r;
          OFF_CIEN: reg_rdata_out[CI_BIT] <= cien_r;
          // Software samples these before enabling
          OFF_CLST: begin
            reg_rdata_out[CL_DAT1] <= dat_s2_r[1];
            reg_rdata_out[CL_PRD]  <= idle;
          end
          OFF_DATA: reg_rdata_out <= fifo_empty ? '0 : {lane[3], lane[2], lane[1], lane[0]};
          OFF_FST: begin
            reg_rdata_out[FS_EMP] <= fifo_empty;
            reg_rdata_out[FS_FUL] <= fifo_full;
          end
          default: ;
        endcase
      end
    end
  end

  // Checks
  a_ready_thresh: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!idle && fifo_cnt_r >= (lev_r ? THR_HI : THR_LO)) |=> st_r[ST_RECV_READY_IRQ]) else $error("ready not set at level");
  a_trail_gap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(st_r[ST_RECV_READY_IRQ]) |-> $past(rdy_cond) || ($past(last_byte) && !($past(lev_r) && $past(trail_rem))))
    else $error("ready raised without cause");
  a_empty_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == OFF_FST) |=> reg_rdata_out[FS_EMP] == ($past(fifo_cnt_r) < {3'h0, $past(acc)}))
    else $error("empty flag wrong");
  a_full_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == OFF_FST) |=>
    reg_rdata_out[FS_FUL] == ((FIFO_BYTES - $past(fifo_cnt_r)) < {3'h0, $past(acc)})) else $error("full flag wrong");
  a_fifo_bound: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fifo_cnt_r <= FIFO_BYTES) else $error("fifo count over 32");
  a_edge_take: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (dat1_prev_r && !dat_s2_r[1] && cien_r && idle) |=> cist_r ##1 cist_r || $past(reg_wr_in))
    else $error("DAT1 edge missed");
  a_level_blind: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(cist_r) |-> $past(dat1_prev_r) && !$past(dat_s2_r[1]) && $past(cien_r)) else $error("irq without edge");
  a_card_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (cist_r && !(reg_wr_in && reg_addr_in == OFF_CIST)) |=> cist_r) else $error("card status lost");
  c_full_xfer: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $rose(st_r[ST_TDONE]));
  c_trail_skip: cover property (@(posedge mclk_in) disable iff (!rst_n_in) last_byte && lev_r && trail_rem);
  c_card_irq: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $rose(cist_r));

endmodule // sd_host_rx

/* File: common/sd_host_pkg.sv */
package sd_host_pkg;
  // Register port widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CMD   = 6'h00; // command_reg
  localparam logic [ADDR_W-1:0] OFF_FCTL  = 6'h04; // fifo_control_reg
  localparam logic [ADDR_W-1:0] OFF_ST0   = 6'h08; // host_status_reg0, W1C
  localparam logic [ADDR_W-1:0] OFF_MASK  = 6'h0c; // Mask of host_status_reg0
  localparam logic [ADDR_W-1:0] OFF_BLEN  = 6'h10; // block_length_reg
  localparam logic [ADDR_W-1:0] OFF_NBLK  = 6'h14; // block_count_reg
  localparam logic [ADDR_W-1:0] OFF_CIST  = 6'h18; // card_irq_status_reg, W1C
  localparam logic [ADDR_W-1:0] OFF_CIEN  = 6'h1c; // card_irq_enable_reg
  localparam logic [ADDR_W-1:0] OFF_CLST  = 6'h20; // card_line_status_reg
  localparam logic [ADDR_W-1:0] OFF_DATA  = 6'h24; // FIFO read port
  localparam logic [ADDR_W-1:0] OFF_FST   = 6'h28; // FIFO flags
  // Field positions
  localparam int ST_DDONE   = 0;  // data_done_flag
  localparam int ST_RECV_READY_IRQ    = 10; // recv_ready_flag
  localparam int ST_TDONE   = 12; // transfer_done_flag
  localparam int CMD_TRIG   = 16; // dma_trigger_bit
  localparam int FC_LEV     = 2;  // fifo_threshold_sel
  localparam int FC_ACC_LO  = 3;  // access_width_sel low bit
  localparam int FC_ACC_HI  = 4;  // access_width_sel high bit
  localparam int CI_BIT     = 0;  // card_irq_status / card_irq_enable
  localparam int CL_DAT1    = 0;  // DAT1 level
  localparam int CL_PRD     = 1;  // irq_period_flag
  localparam int FS_EMP     = 0;  // fifo_empty_flag
  localparam int FS_FUL     = 1;  // fifo_full_flag
  localparam int BLEN_W     = 12;
  localparam int NBLK_W     = 16;
  localparam int TOT_W      = BLEN_W + NBLK_W;
  // Sticky bits of host_status_reg0
  localparam logic [DATA_W-1:0] ST_BITS = 32'h0000_1401;
  // FIFO sizing in bytes
  localparam logic [5:0] FIFO_BYTES = 6'h20;
  localparam logic [5:0] THR_LO     = 6'h10; // 128-bit level
  localparam logic [5:0] THR_HI     = 6'h20; // 256-bit level
  localparam logic [4:0] TRAIL_MAX  = 5'h03; // Unflagged trailing bytes
  // Access width codes
  localparam logic [1:0] ACC_4 = 2'h0;
  localparam logic [1:0] ACC_1 = 2'h1;
  localparam logic [1:0] ACC_2 = 2'h2;
  // Receive sequencer
  typedef enum logic [1:0] {XS_IDLE, XS_RECV, XS_DRAIN} xfer_state_t;
  // Bytes per FIFO access for an access_width_sel code
  function automatic logic [2:0] acc_bytes(input logic [1:0] sel);
    case (sel)
      ACC_1:   acc_bytes = 3'h1;
      ACC_2:   acc_bytes = 3'h2;
      default: acc_bytes = 3'h4;
    endcase
  endfunction
endpackage

/* File: tb/sd_card_model.sv */
`timescale 1ns/1ps
module sd_card_model (
  // Card bus pins seen by the host
  output logic       sd_clk_out,
  output logic [3:0] sd_dat_out
);
  logic irq_low; // Card holds DAT1 low to signal an interrupt

  // Clock stands low between frames; pulled-up lines idle high
  initial begin
    sd_clk_out = 1'b0;
    sd_dat_out = 4'hf;
    irq_low    = 1'b0;
  end

  // One byte, high nibble on the first rise, 200 ns clock only inside the frame
  task automatic send_byte(input logic [7:0] b);
    #7;
    for (int i = 1; i >= 0; i--) begin
      sd_dat_out = b[4*i +: 4];
      #100 sd_clk_out = 1'b1;
      #100 sd_clk_out = 1'b0;
    end
    // Released lines return to the pull-up level, DAT1 shows the interrupt
    sd_dat_out = {2'b11, ~irq_low, 1'b1};
  endtask

  // Raise or withdraw the card interrupt; withdrawing is the function driver's clear
  task automatic set_irq(input logic low);
    // Move off the host clock edge so the pin never races its sampling flop
    #7;
    irq_low       = low;
    sd_dat_out[1] = ~low;
  endtask
endmodule // sd_card_model

/* File: tb/sd_host_rx_tb.sv */
`timescale 1ns/1ps
module sd_host_rx_tb;
  import sd_host_pkg::*;
  // Design stimulus and observation
  logic              mclk_in      = 1'b0;
  logic              rst_n_in     = 1'b0;
  logic [ADDR_W-1:0] reg_addr_in  = '0;
  logic [DATA_W-1:0] reg_wdata_in = '0;
  logic              reg_wr_in    = 1'b0;
  logic              reg_rd_in    = 1'b0;
  logic [DATA_W-1:0] reg_rdata_out;
  logic              sd_clk_in;
  logic [3:0]        sd_dat_in;
  logic              irq_out;
  logic              dma_rd_event_out;
  // Bench bookkeeping
  int                fails        = 0;
  int                tests_run    = 0;
  int                dma_cnt      = 0;
  int                cyc          = 0;
  logic              rd_seen      = 1'b0;
  logic [31:0]       exp_q[$];
  logic [7:0]        data [0:31];

  // 40 MHz system clock
  always #12.5 mclk_in = ~mclk_in;

  sd_host_rx i_dut (
    .mclk_in          (mclk_in),
    .rst_n_in         (rst_n_in),
    .reg_addr_in      (reg_addr_in),
    .reg_wdata_in     (reg_wdata_in),
    .reg_wr_in        (reg_wr_in),
    .reg_rd_in        (reg_rd_in),
    .reg_rdata_out    (reg_rdata_out),
    .sd_clk_in        (sd_clk_in),
    .sd_dat_in        (sd_dat_in),
    .irq_out          (irq_out),
    .dma_rd_event_out (dma_rd_event_out)
  );

  sd_card_model i_card (
    .sd_clk_out (sd_clk_in),
    .sd_dat_out (sd_dat_in)
  );

  // Single comparison point; case inequality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts first, then the verdict, from one place only
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in    <= 1'b0;
  endtask

  // One-cycle read strobe; expectation queued for the monitor
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk_in);
    reg_rd_in   <= 1'b0;
  endtask

  // Interrupt level looked at mid-cycle, where it has settled
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    check({31'h0, irq_out}, {31'h0, e});
  endtask

  // Expected flag word for n bytes held and an access size of acc bytes
  function automatic logic [31:0] flags(input int n, input int acc);
    return {30'h0, (32 - n) < acc, n < acc};
  endfunction

  // Read data stands only in the cycle after the strobe: compare it there
  always @(posedge mclk_in) begin
    if (rd_seen && exp_q.size() > 0) begin
      check(reg_rdata_out, exp_q.pop_front());
    end
    rd_seen <= reg_rd_in;
    if (dma_rd_event_out === 1'b1) begin
      dma_cnt++;
    end
  end

  // Hang guard, well above the roughly 1100 cycles the sequence needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    int base;
    int acc;
    void'($urandom(32'h62c2125d));
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    // Values after reset, and an unmapped place
    rd(OFF_CLST, 32'h3);
    rd(OFF_FST, 32'h1);
    rd(6'h3c, 32'h0);
    // Fill the whole FIFO at the 256-bit level, flags checked at every count
    wr(OFF_FCTL, 32'h4);
    wr(OFF_BLEN, 32'd32);
    wr(OFF_NBLK, 32'd1);
    base = dma_cnt;
    wr(OFF_CMD, 32'h0001_0000);
    for (int i = 0; i < 32; i++) begin
      data[i] = 8'($urandom);
      i_card.send_byte(data[i]);
      repeat (6) @(posedge mclk_in);
      if (i == 0 || i == 28) begin
        // Sweep every width code where the flags depend on it
        for (int w = 0; w < 4; w++) begin
          acc = (w == 1) ? 1 : (w == 2) ? 2 : 4;
          wr(OFF_FCTL, {27'h0, 2'(w), 1'b1, 2'h0});
          rd(OFF_FST, flags(i + 1, acc));
        end
        wr(OFF_FCTL, 32'h4);
      end else begin
        rd(OFF_FST, flags(i + 1, 4));
      end
    end
    rd(OFF_ST0, 32'h0000_0401);
    check({31'h0, dma_cnt != base}, 32'h1);
    // Drain four bytes per access, then two; first byte in the low lane
    wr(OFF_FCTL, 32'h4);
    for (int k = 0; k < 4; k++) begin
      rd(OFF_DATA, {data[4*k+3], data[4*k+2], data[4*k+1], data[4*k]});
    end
    wr(OFF_FCTL, 32'h14);
    for (int k = 8; k < 16; k++) begin
      rd(OFF_DATA, {16'h0, data[2*k+1], data[2*k]});
    end
    repeat (4) @(posedge mclk_in);
    rd(OFF_ST0, 32'h0000_1401);
    rd(OFF_DATA, 32'h0);
    rd(OFF_FST, 32'h1);
    wr(OFF_ST0, 32'h0000_1401);
    rd(OFF_ST0, 32'h0);
    // Three trailing bytes at both levels; ready only at the 128-bit level
    for (int thr = 1; thr >= 0; thr--) begin
      wr(OFF_FCTL, {27'h0, 2'h1, 1'(thr), 2'h0});
      wr(OFF_BLEN, 32'd3);
      wr(OFF_NBLK, 32'd1);
      wr(OFF_MASK, 32'h1);
      base = dma_cnt;
      wr(OFF_CMD, 32'h0001_0000);
      for (int i = 0; i < 3; i++) begin
        data[i] = 8'($urandom);
        i_card.send_byte(data[i]);
      end
      repeat (8) @(posedge mclk_in);
      rd(OFF_ST0, (thr == 1) ? 32'h1 : 32'h401);
      check({31'h0, dma_cnt != base}, {31'h0, thr == 0});
      chk_irq(1'b1);
      for (int k = 0; k < 3; k++) begin
        rd(OFF_DATA, {24'h0, data[k]});
      end
      repeat (4) @(posedge mclk_in);
      rd(OFF_ST0, (thr == 1) ? 32'h1001 : 32'h1401);
      wr(OFF_MASK, 32'h0);
      chk_irq(1'b0);
      wr(OFF_ST0, 32'h0000_1401);
    end
    // Card interrupt already low before enabling goes unseen
    i_card.set_irq(1'b1);
    repeat (6) @(posedge mclk_in);
    rd(OFF_CLST, 32'h2);
    wr(OFF_CIEN, 32'h1);
    repeat (6) @(posedge mclk_in);
    rd(OFF_CIST, 32'h0);
    chk_irq(1'b0);
    // A fresh falling edge is caught and held until cleared
    i_card.set_irq(1'b0);
    repeat (6) @(posedge mclk_in);
    i_card.set_irq(1'b1);
    repeat (8) @(posedge mclk_in);
    rd(OFF_CIST, 32'h1);
    rd(OFF_CIST, 32'h1);
    chk_irq(1'b1);
    // Service order: clear status, mask, then the card drops its source
    wr(OFF_CIST, 32'h1);
    wr(OFF_CIEN, 32'h0);
    i_card.set_irq(1'b0);
    repeat (6) @(posedge mclk_in);
    rd(OFF_CIST, 32'h0);
    chk_irq(1'b0);
    repeat (4) @(posedge mclk_in);
    test_done();
  end
endmodule // sd_host_rx_tb
